// File: logic/atm_map.svh
// register offsets, field positions, reset values and the unmapped read answer
// assumes inclusion by bare name from the package, the property module and the testbench
`ifndef ATM_MAP_SVH
`define ATM_MAP_SVH
// register word addresses
`define ATM_A_CTRL 8'h00
`define ATM_A_DIVIDER 8'h04
`define ATM_A_RELOAD 8'h08
`define ATM_A_STATUS 8'h0c
`define ATM_A_IRQEN 8'h10
`define ATM_A_CHMODE 8'h14
`define ATM_A_OUTEN 8'h18
`define ATM_A_FAULT 8'h1c
`define ATM_A_COUNT 8'h20
`define ATM_A_CC0 8'h24
// ctrl fields
`define ATM_C_RUN 0
`define ATM_C_DOWN 1
`define ATM_C_CENTER 2
`define ATM_C_ONESHOT 3
`define ATM_C_DMA 4
`define ATM_C_PWMIN 5
// fault register fields
`define ATM_F_MOE 8
`define ATM_F_FAULT_STOP_ENABLE 9
`define ATM_F_FAULT_INPUT_POLARITY 10
`define ATM_F_RUNOFF 11
`define ATM_F_IDLEOFF 12
// reset values
`define ATM_RST_RELOAD 16'hffff
`define ATM_RST_ZERO 16'h0000
// unmapped read answer
`define ATM_RD_NONE 32'h0000_0000
`endif

// File: logic/atm_pkg.sv
// types shared by the advanced timer compare/capture stage
// assumes atm_map.svh sits on the include path
package atm_pkg;
  `include "atm_map.svh"
  // compare mode codes
  typedef enum logic [2:0] {
    ATM_FREEZE, ATM_ACT_MATCH, ATM_INACT_MATCH, ATM_TOGGLE,
    ATM_FORCE_LO, ATM_FORCE_HI, ATM_PWM1, ATM_PWM2
  } atm_mode_type;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atm_bus_type;
  // per-channel config field
  typedef struct packed {
    logic [1:0] dir;
    atm_mode_type mode;
    logic [1:0] evdiv;
    logic edge_fall;
  } atm_chcfg_type;
endpackage

// File: logic/atm_timer.sv
// advanced timer: divider, counter, four capture/compare channels, dead-time outputs
// assumes synchronous inputs, one 200 MHz clock, software on a plain register port
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
// ==========================================
// Overview of operation
// - 16-bit divider clocks the main counter
// - divider value buffered while running
// - buffered values load on update event
// - four independent capture/compare channels
// - inputs filtered and edge detected first
// - capture copies main counter value
// - event divider per capture channel
// - capture sets flag, optional interrupt
// - eight compare modes per channel
// - match sets, clears or toggles output
// - flag gives interrupt or dma request
// - reload sets period, compare sets width
// - pwm1 active while counter below compare
// - pwm2 inactive while counter below compare
// - pwm input: ch1 feeds ch1, ch2
// - one shot stops counter at update
// - enables off gives inactive outputs
// - idle mode drives idle levels
// - polarity bit selects active level
// - fault input forces safe outputs
// - three pairs with dead-time
// - forced modes ignore compare, keep flags
module atm_timer #(
  parameter int CHANNELS = 4,
  parameter int FILTER_LEN = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire atm_pkg::atm_bus_type bus,
  output logic [31:0] rdata,
  input wire logic [3:0] ch_in,
  input wire logic fault_in,
  input wire logic clock_fail,
  output logic [3:0] ch_out,
  output logic [2:0] ch_out_n,
  output logic irq,
  output logic dma_req
);
  import atm_pkg::*;

  // ==========================================
  // registers
  logic [7:0] ctrl_q;
  logic [15:0] div_buf_q, div_act_q, div_cnt_q;
  logic [15:0] reload_buf_q, reload_act_q;
  logic [15:0] main_counter_q;
  logic dir_down_q;
  logic [3:0] flag_q, irqen_q;
  atm_chcfg_type [3:0] cfg_q;
  logic [3:0] out_en_q, comp_en_q, out_pol_q, comp_pol_q;
  logic [3:0] idle_lvl_q, comp_idle_q;
  logic [12:0] fault_q;
  logic [15:0] cc_q [4];
  logic [3:0] ref_q;
  logic [1:0] evcnt_q [4];
  logic [FILTER_LEN-1:0] filt_q [4];
  logic [3:0] stable_q, stable_old_q;
  logic [7:0] dt_cnt_q [3];
  logic moe_q;

  // ==========================================
  // decode
  wire wr_ctrl = bus.wr && bus.addr == `ATM_A_CTRL;
  wire wr_div = bus.wr && bus.addr == `ATM_A_DIVIDER;
  wire wr_rel = bus.wr && bus.addr == `ATM_A_RELOAD;
  wire wr_sts = bus.wr && bus.addr == `ATM_A_STATUS;
  wire wr_ien = bus.wr && bus.addr == `ATM_A_IRQEN;
  wire wr_mode = bus.wr && bus.addr == `ATM_A_CHMODE;
  wire wr_oen = bus.wr && bus.addr == `ATM_A_OUTEN;
  wire wr_flt = bus.wr && bus.addr == `ATM_A_FAULT;
  wire wr_cnt = bus.wr && bus.addr == `ATM_A_COUNT;
  wire run = ctrl_q[`ATM_C_RUN];
  wire center = ctrl_q[`ATM_C_CENTER];
  wire [7:0] dead_time_setting = fault_q[7:0];

  wire tick = run && (div_cnt_q == div_act_q);
  // counter ends of period
  wire at_top = main_counter_q >= reload_act_q;
  wire at_bot = main_counter_q == `ATM_RST_ZERO;
  wire up_mode = center ? !dir_down_q : !ctrl_q[`ATM_C_DOWN];
  // center turns: overrun one below reload going up, underrun at one going down
  wire turn_up = !dir_down_q && main_counter_q + 16'h0001 >= reload_act_q;
  wire turn_dn = dir_down_q && main_counter_q == 16'h0001;
  // update event on wrap, or on either turn in center mode
  wire update = tick && (center ? (turn_up || turn_dn) : (up_mode ? at_top : at_bot));

  // fault qualified by enable and polarity
  wire fault_hit = fault_q[`ATM_F_FAULT_STOP_ENABLE] &&
                   ((fault_in ^ fault_q[`ATM_F_FAULT_INPUT_POLARITY]) || clock_fail);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_q <= `ATM_RST_ZERO;
    end else if (!run || tick) begin
      div_cnt_q <= `ATM_RST_ZERO;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_act_q <= `ATM_RST_ZERO;
      reload_act_q <= `ATM_RST_RELOAD;
    end else if (update) begin
      div_act_q <= div_buf_q;
      reload_act_q <= reload_buf_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_counter_q <= `ATM_RST_ZERO;
      dir_down_q <= 1'b0;
    end else if (wr_cnt) begin
      main_counter_q <= bus.wdata[15:0];
    end else if (tick) begin
      if (center) begin
        if (turn_up) begin
          dir_down_q <= 1'b1;
        end else if (turn_dn) begin
          dir_down_q <= 1'b0;
        end
        main_counter_q <= dir_down_q ? main_counter_q - 16'h0001 : main_counter_q + 16'h0001;
      end else if (up_mode) begin
        main_counter_q <= at_top ? `ATM_RST_ZERO : main_counter_q + 16'h0001;
      end else begin
        main_counter_q <= at_bot ? reload_act_q : main_counter_q - 16'h0001;
      end
    end
  end

  // ==========================================
  // input path per channel
  // ch2 may take ch1 input, inverted edge
  function automatic logic pick_in(input logic [3:0] pins, input int ch, input logic pwmin);
    pick_in = (pwmin && ch == 1) ? pins[0] : pins[ch];
  endfunction

  logic [3:0] cap_edge, cap_fire, match;
  logic [3:0] ch_raw;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ch_raw[i] = pick_in(ch_in, i, ctrl_q[`ATM_C_PWMIN]);
      cap_edge[i] = (stable_q[i] != stable_old_q[i]) &&
                    (stable_q[i] ^ cfg_q[i].edge_fall ^
                     (ctrl_q[`ATM_C_PWMIN] && i == 1));
      // fire when event count reaches divide
      cap_fire[i] = cap_edge[i] && cfg_q[i].dir != 2'b00 &&
                    evcnt_q[i] == cfg_q[i].evdiv;
      match[i] = cfg_q[i].dir == 2'b00 && main_counter_q == cc_q[i];
    end
  end

  // filter: level must hold FILTER_LEN+1 clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        filt_q[i] <= '0;
      end
      stable_q <= 4'h0;
      stable_old_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        filt_q[i] <= {filt_q[i][FILTER_LEN-2:0], ch_raw[i]};
        if (&{filt_q[i], ch_raw[i]} || !(|{filt_q[i], ch_raw[i]})) begin
          stable_q[i] <= ch_raw[i];
        end
      end
      stable_old_q <= stable_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        cc_q[i] <= `ATM_RST_ZERO;
        evcnt_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cap_fire[i]) begin
          cc_q[i] <= main_counter_q;
        end else if (bus.wr && bus.addr == `ATM_A_CC0 + 8'(4 * i)) begin
          cc_q[i] <= bus.wdata[15:0];
        end
        if (cap_edge[i] && cfg_q[i].dir != 2'b00) begin
          evcnt_q[i] <= cap_fire[i] ? 2'h0 : evcnt_q[i] + 2'h1;
        end
      end
    end
  end

  // flags: hardware set wins over clear
  // forced modes still set flags on match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= (flag_q & ~(wr_sts ? ~bus.wdata[3:0] : 4'h0)) | cap_fire | (match & {4{tick}});
    end
  end

  // ==========================================
  // reference per mode
  logic [3:0] ref_d;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      case (cfg_q[i].mode)
        ATM_FREEZE: ref_d[i] = ref_q[i];
        ATM_ACT_MATCH: ref_d[i] = match[i] ? 1'b1 : ref_q[i];
        ATM_INACT_MATCH: ref_d[i] = match[i] ? 1'b0 : ref_q[i];
        ATM_TOGGLE: ref_d[i] = (match[i] && tick) ? !ref_q[i] : ref_q[i];
        ATM_FORCE_LO: ref_d[i] = 1'b0;
        ATM_FORCE_HI: ref_d[i] = 1'b1;
        ATM_PWM1: ref_d[i] = main_counter_q < cc_q[i];
        ATM_PWM2: ref_d[i] = !(main_counter_q < cc_q[i]);
        default: ref_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q <= 4'h0;
    end else begin
      ref_q <= ref_d;
    end
  end

  // ==========================================
  // dead-time: delay each rising edge of pair legs
  logic [2:0] out_leg, comp_leg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 3; i++) begin
        dt_cnt_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        // restart as the reference changes, so the gap is exactly the setting
        if (ref_d[i] != ref_q[i]) begin
          dt_cnt_q[i] <= 8'h00;
        end else if (dt_cnt_q[i] < dead_time_setting) begin
          dt_cnt_q[i] <= dt_cnt_q[i] + 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      out_leg[i] = ref_q[i] && dt_cnt_q[i] >= dead_time_setting;
      comp_leg[i] = !ref_q[i] && dt_cnt_q[i] >= dead_time_setting;
    end
  end

  // main output enable drops on fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      moe_q <= 1'b0;
    end else if (fault_hit) begin
      moe_q <= 1'b0;
    end else if (wr_flt) begin
      moe_q <= bus.wdata[`ATM_F_MOE];
    end
  end

  // channel 3 has no pair and takes its reference straight
  wire [3:0] leg_all = {ref_q[3], out_leg};
  // output stage: polarity, enables, idle, fault
  logic [3:0] out_d;
  logic [2:0] out_n_d;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      out_d[i] = leg_all[i] && out_en_q[i];
      out_d[i] = out_d[i] ^ out_pol_q[i];
      // idle level when main enable low
      if (!moe_q) begin
        out_d[i] = idle_lvl_q[i];
      end
    end
    for (int i = 0; i < 3; i++) begin
      out_n_d[i] = (comp_leg[i] && comp_en_q[i]) ^ comp_pol_q[i];
      if (!moe_q) begin
        out_n_d[i] = comp_idle_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00;
    end else if (wr_ctrl) begin
      ctrl_q <= bus.wdata[7:0];
    end else if (update && ctrl_q[`ATM_C_ONESHOT]) begin
      ctrl_q[`ATM_C_RUN] <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_buf_q <= `ATM_RST_ZERO;
      reload_buf_q <= `ATM_RST_RELOAD;
      irqen_q <= 4'h0;
      cfg_q <= '0;
      {comp_idle_q, idle_lvl_q, comp_pol_q, out_pol_q, comp_en_q, out_en_q} <= 24'h00_0000;
      fault_q <= 13'h0000;
    end else begin
      if (wr_div) div_buf_q <= bus.wdata[15:0];
      if (wr_rel) reload_buf_q <= bus.wdata[15:0];
      if (wr_ien) irqen_q <= bus.wdata[3:0];
      if (wr_mode) cfg_q <= bus.wdata[31:0];
      if (wr_oen) begin
        {comp_idle_q, idle_lvl_q, comp_pol_q, out_pol_q, comp_en_q, out_en_q} <= bus.wdata[23:0];
      end
      if (wr_flt) fault_q <= bus.wdata[12:0];
    end
  end

  // read mux, data one cycle after strobe
  logic [31:0] rd_d;
  always_comb begin
    case (bus.addr)
      `ATM_A_CTRL: rd_d = {24'h00_0000, ctrl_q};
      `ATM_A_DIVIDER: rd_d = {16'h0000, div_buf_q};
      `ATM_A_RELOAD: rd_d = {16'h0000, reload_buf_q};
      `ATM_A_STATUS: rd_d = {28'h000_0000, flag_q};
      `ATM_A_IRQEN: rd_d = {28'h000_0000, irqen_q};
      `ATM_A_CHMODE: rd_d = cfg_q;
      `ATM_A_OUTEN: rd_d = {8'h00, comp_idle_q, idle_lvl_q, comp_pol_q, out_pol_q,
                            comp_en_q, out_en_q};
      `ATM_A_FAULT: rd_d = {19'h0_0000, fault_q[12:9], moe_q, fault_q[7:0]};
      `ATM_A_COUNT: rd_d = {16'h0000, main_counter_q};
      8'h24: rd_d = {16'h0000, cc_q[0]};
      8'h28: rd_d = {16'h0000, cc_q[1]};
      8'h2c: rd_d = {16'h0000, cc_q[2]};
      8'h30: rd_d = {16'h0000, cc_q[3]};
      default: rd_d = `ATM_RD_NONE;
    endcase
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `ATM_RD_NONE;
      ch_out <= 4'h0;
      ch_out_n <= 3'h0;
    end else begin
      rdata <= bus.rd ? rd_d : `ATM_RD_NONE;
      ch_out <= out_d;
      ch_out_n <= out_n_d;
    end
  end

  assign irq = |(flag_q & irqen_q);
  assign dma_req = ctrl_q[`ATM_C_DMA] && |flag_q;
endmodule

// File: testbench/atm_props.sv
// port checks for the timer, shadowing a few control bits seen on the bus
// assumes bound onto atm_timer, one clock, strobes one cycle long
`timescale 1ns/100ps
`include "atm_map.svh"
module atm_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire atm_pkg::atm_bus_type bus,
  input wire logic [31:0] rdata,
  input wire logic [3:0] ch_in,
  input wire logic fault_in,
  input wire logic clock_fail,
  input wire logic [3:0] ch_out,
  input wire logic [2:0] ch_out_n,
  input wire logic irq,
  input wire logic dma_req
);
  import atm_pkg::*;
  // ====
  // shadow state
  logic [23:0] oe_q;
  logic [3:0] ien_q;
  logic [3:0] quiet_q;
  logic [7:0] dt_q;
  logic dma_q, moe_q, brk_q;
  wire wr_oe = bus.wr && bus.addr == `ATM_A_OUTEN;
  wire wr_flt = bus.wr && bus.addr == `ATM_A_FAULT;
  wire rd_bad = bus.rd && (bus.addr > 8'h30 || bus.addr[1:0] != 2'b00);
  // quiet counts cycles since output setup changed, outputs lag a few clocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {oe_q, ien_q, dt_q, dma_q, moe_q, brk_q} <= '0;
      quiet_q <= 4'h0;
    end else begin
      if (wr_oe) oe_q <= bus.wdata[23:0];
      if (wr_flt) {brk_q, moe_q, dt_q} <= bus.wdata[9:0];
      if (bus.wr && bus.addr == `ATM_A_IRQEN) ien_q <= bus.wdata[3:0];
      if (bus.wr && bus.addr == `ATM_A_CTRL) dma_q <= bus.wdata[`ATM_C_DMA];
      quiet_q <= (wr_oe || wr_flt) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // assertions
  rdata_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0000_0000)
    else $error("read data not zero outside read answer");
  rdata_unmapped_a: assert property ($past(rd_bad) |-> rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  reset_quiet_a: assert property ($rose(rst_n) |-> ch_out == 4'h0 && ch_out_n == 3'h0 && !irq)
    else $error("outputs not idle after reset");
  no_overlap_a: assert property (oe_q[23:8] == 16'h0 && quiet_q == 4'hf |->
    (ch_out[2:0] & ch_out_n) == 3'h0) else $error("pair active together");
  moe_off_a: assert property (!moe_q && oe_q[23:16] == 8'h0 && quiet_q == 4'hf |->
    ch_out == 4'h0 && ch_out_n == 3'h0) else $error("idle mode output not at idle level");
  en_off_a: assert property (oe_q[23:0] == 24'h0 && quiet_q == 4'hf |->
    (ch_out[2:0] | ch_out_n) == 3'h0) else $error("disabled output active");
  brk_stop_a: assert property (brk_q && clock_fail && oe_q[23:16] == 8'h0 |->
    ##[1:8] (ch_out == 4'h0 && ch_out_n == 3'h0)) else $error("fault left outputs driven");
  irq_quiet_a: assert property (ien_q == 4'h0 |-> !irq)
    else $error("interrupt while all masked");
  dma_quiet_a: assert property (!dma_q |-> !dma_req)
    else $error("dma request while not selected");
  dead_gap_a: assert property ($fell(ch_out[0]) && dt_q >= 8'h04 && oe_q[23:8] == 16'h0 |->
    ch_out_n[0] == 1'b0 [*4]) else $error("complement rose inside dead-time");
endmodule
bind atm_timer atm_props u_props (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
  .ch_in(ch_in), .fault_in(fault_in), .clock_fail(clock_fail), .ch_out(ch_out),
  .ch_out_n(ch_out_n), .irq(irq), .dma_req(dma_req));

// File: testbench/atm_pins.sv
// pin side of the timer: a pulse source on capture input 0, a quiet fault pin
// assumes go is one cycle long and synchronous to clk
`timescale 1ns/100ps
module atm_pins (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [15:0] hi_len,
  output logic [3:0] ch_in,
  output logic fault_in
);
  // ====
  // pulse high for hi_len cycles, both edges land on clock edges
  logic [15:0] left_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) left_q <= 16'h0000;
    else if (go) left_q <= hi_len;
    else if (left_q != 16'h0000) left_q <= left_q - 16'h0001;
  end
  // other inputs and the fault pin rest at their pulled-down level
  assign ch_in = {3'b000, left_q != 16'h0000};
  assign fault_in = 1'b0;
endmodule

// File: testbench/testbench.sv
// self-checking bench: registers, divider, compare modes, capture, dead-time, fault
// assumes atm_pins on the pins and atm_props bound onto the design
`timescale 1ns/100ps
`include "atm_map.svh"
module testbench;
  import atm_pkg::*;
  logic clk, rst_n, clock_fail, go, irq, dma_req, fault_in;
  atm_bus_type bus;
  logic [31:0] rdata, v, w, cc, hl, dt, seed;
  logic [3:0] ch_in, ch_out;
  logic [2:0] ch_out_n;
  logic [15:0] hi_len;
  int n_mismatch, check_count, n;
  atm_mode_type md[9] = '{ATM_ACT_MATCH, ATM_FREEZE, ATM_INACT_MATCH, ATM_TOGGLE,
    ATM_FORCE_LO, ATM_FORCE_HI, ATM_PWM1, ATM_PWM2, ATM_PWM1};
  logic pl[9] = '{0, 0, 0, 0, 0, 0, 0, 0, 1};
  atm_timer #(.CHANNELS(4), .FILTER_LEN(2)) dut (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .ch_in(ch_in), .fault_in(fault_in), .clock_fail(clock_fail),
    .ch_out(ch_out), .ch_out_n(ch_out_n), .irq(irq), .dma_req(dma_req));
  atm_pins pins (.clk(clk), .rst_n(rst_n), .go(go), .hi_len(hi_len), .ch_in(ch_in),
    .fault_in(fault_in));
  // ====
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // high cycles of channel 3 over two periods of 400 clocks
  function automatic int pwm_high(atm_mode_type m, logic p, int c);
    int h;
    case (m)
      ATM_PWM1: h = c * 8;
      ATM_PWM2: h = 800 - c * 8;
      ATM_FORCE_LO, ATM_INACT_MATCH: h = 0;
      ATM_TOGGLE: h = 400;
      default: h = 800;
    endcase
    return p ? 800 - h : h;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic count_high(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(posedge clk);
      if (ch_out[3] === 1'b1) h++;
    end
  endtask
  task automatic pulse(input logic [15:0] h);
    @(posedge clk);
    go <= 1'b1;
    hi_len <= h;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog: one full 65536-count wrap plus about 15000 cycles of tests
  initial begin
    #450000;
    n_mismatch++;
    results();
  end
  initial begin
    {rst_n, clock_fail, go, hi_len, bus, seed} = {3'b000, 16'h0000, 42'h0, 32'd58703};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wr(8'h44, rnd());
    rd(8'h44, v); chk("unmapped", v, 32'h0000_0000);
    rd(`ATM_A_RELOAD, v); chk("reload reset", v, 32'h0000_ffff);
    // new divider and reload wait for the wrap at the old reload
    wr(`ATM_A_DIVIDER, 32'h0000_0003);
    wr(`ATM_A_RELOAD, 32'h0000_0063);
    wr(`ATM_A_CTRL, 32'h0000_0001);
    repeat (300) @(posedge clk);
    rd(`ATM_A_COUNT, v); chk("before update", v > 32'd250, 1'b1);
    repeat (65400) @(posedge clk);
    rd(`ATM_A_COUNT, v); chk("after update", v < 32'd100, 1'b1);
    repeat (38) @(posedge clk);
    rd(`ATM_A_COUNT, w); chk("divide by 4", (w + 32'd100 - v) % 32'd100, 32'd10);
    $display("done: divider");
    // compare modes on channel 3, random width
    cc = 32'd1 + rnd() % 32'd98;
    wr(`ATM_A_CC0 + 8'h0c, cc);
    wr(`ATM_A_FAULT, 32'h0000_0100);
    foreach (md[i]) begin
      wr(`ATM_A_OUTEN, {20'h0_0000, pl[i], 11'h008});
      wr(`ATM_A_CHMODE, {atm_chcfg_type'{2'b00, md[i], 2'b00, 1'b0}, 24'h00_0000});
      repeat (400) @(posedge clk);
      count_high(800, n);
      chk("duty", n, pwm_high(md[i], pl[i], cc));
    end
    // pwm1 inverted, counting down, then center: 198 counts a period
    wr(`ATM_A_CTRL, 32'h0000_0003);
    repeat (400) @(posedge clk);
    count_high(800, n);
    chk("duty down", n, pwm_high(ATM_PWM1, 1'b1, cc));
    wr(`ATM_A_CTRL, 32'h0000_0005);
    repeat (800) @(posedge clk);
    count_high(792, n);
    chk("duty center", n, 32'd796 - 32'd8 * cc);
    rd(`ATM_A_STATUS, v); chk("compare flag", v[3], 1'b1);
    wr(`ATM_A_IRQEN, 32'h0000_0008);
    wr(`ATM_A_CTRL, 32'h0000_0011);
    @(negedge clk);
    chk("irq and dma", {irq, dma_req}, 2'b11);
    $display("done: compare");
    // pulse width seen by channels 0 and 1 from input 0
    // follower reset lives outside, width is a capture difference
    wr(`ATM_A_IRQEN, 32'h0000_0000);
    wr(`ATM_A_CHMODE, 32'h0000_4040);
    wr(`ATM_A_STATUS, 32'h0000_0000);
    wr(`ATM_A_CTRL, 32'h0000_0021);
    hl = 32'd4 * (32'd10 + rnd() % 32'd80);
    pulse(hl[15:0]);
    repeat (hl + 32'd30) @(posedge clk);
    rd(`ATM_A_CC0, v);
    rd(`ATM_A_CC0 + 8'h04, w);
    chk("pulse width", (w + 32'd100 - v) % 32'd100, hl / 32'd4);
    rd(`ATM_A_STATUS, v); chk("capture flags", v[1:0], 2'b11);
    wr(`ATM_A_IRQEN, 32'h0000_0001);
    @(negedge clk);
    chk("capture irq", irq, 1'b1);
    // every second rising edge captures
    wr(`ATM_A_IRQEN, 32'h0000_0000);
    wr(`ATM_A_CHMODE, 32'h0000_0042);
    wr(`ATM_A_STATUS, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      pulse(16'h0028);
      repeat (60) @(posedge clk);
      rd(`ATM_A_STATUS, v); chk("event divider", v[0], k[0]);
    end
    $display("done: capture");
    // one shot freezes the counter at the next update
    wr(`ATM_A_CTRL, 32'h0000_0009);
    repeat (500) @(posedge clk);
    rd(`ATM_A_COUNT, v);
    repeat (38) @(posedge clk);
    rd(`ATM_A_COUNT, w); chk("one shot stop", w, v);
    $display("done: one shot");
    // dead-time on pair 0, counted in clocks
    dt = 32'd4 + rnd() % 32'd12;
    wr(`ATM_A_CTRL, 32'h0000_0001);
    wr(`ATM_A_FAULT, 32'h0000_0100 | dt);
    wr(`ATM_A_OUTEN, 32'h0000_0011);
    wr(`ATM_A_CHMODE, 32'h0000_0028);
    repeat (40) @(posedge clk);
    chk("pair high", {ch_out[0], ch_out_n[0]}, 2'b10);
    wr(`ATM_A_CHMODE, 32'h0000_0020);
    n = 0;
    while (ch_out[0] !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (ch_out_n[0] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk("dead-time", n, dt);
    $display("done: dead-time");
    // clock failure trips the break and clears run mode
    wr(`ATM_A_FAULT, 32'h0000_0300 | dt);
    @(posedge clk);
    clock_fail <= 1'b1;
    repeat (2) @(posedge clk);
    clock_fail <= 1'b0;
    repeat (20) @(posedge clk);
    chk("break outputs", {ch_out, ch_out_n}, 7'h00);
    rd(`ATM_A_FAULT, v); chk("run mode off", v[`ATM_F_MOE], 1'b0);
    // quiet fault pin keeps run mode, inverted polarity trips it
    wr(`ATM_A_FAULT, 32'h0000_0300 | dt);
    rd(`ATM_A_FAULT, v); chk("break quiet", v[`ATM_F_MOE], 1'b1);
    wr(`ATM_A_FAULT, 32'h0000_0700 | dt);
    rd(`ATM_A_FAULT, v); chk("break polarity", v[`ATM_F_MOE], 1'b0);
    // idle levels high in idle mode
    wr(`ATM_A_OUTEN, 32'h00ff_0011);
    repeat (40) @(posedge clk);
    chk("idle high", {ch_out, ch_out_n}, 7'h7f);
    $display("done: break and idle");
    results();
  end
endmodule
